// ==== pkg/culi_pkg.sv ====
package culi_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned SLOW_BLINK_MS   = 500;
  localparam int unsigned FAST_BLINK_MS   = 125;
  localparam int unsigned LOAD_WINDOW_MS  = 100;
  localparam int unsigned SLOW_HALF_CYC   = CLK_HZ / 1000 * SLOW_BLINK_MS;
  localparam int unsigned FAST_HALF_CYC   = CLK_HZ / 1000 * FAST_BLINK_MS;
  localparam int unsigned WINDOW_CYC      = CLK_HZ / 1000 * LOAD_WINDOW_MS;
  localparam int unsigned NSEG            = 8;
  localparam int unsigned DYN_STEP_MS     = 60;
  localparam int unsigned DYN_STEP_CYC    = CLK_HZ / 1000 * DYN_STEP_MS;
  // Bits in one window that count as full load in one direction
  localparam int unsigned FULL_LOAD_BITS  = 100000;

  typedef enum logic [2:0] {
    CULI_OFF    = 3'h0,
    CULI_YELLOW = 3'h1,
    CULI_GREEN  = 3'h2,
    CULI_RED    = 3'h3,
    CULI_WHITE  = 3'h4,
    CULI_BLUE   = 3'h5
  } culi_colour_e;

  typedef enum logic [4:0] {
    CULI_ST_OFF  = 5'h01,
    CULI_ST_SLOW = 5'h02,
    CULI_ST_FAST = 5'h04,
    CULI_ST_ON   = 5'h08,
    CULI_ST_DYN  = 5'h10
  } culi_pattern_e;
endpackage

// ==== verilog/culi_load_meter.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bit counter per direction; latches a segment count each window.
module culi_load_meter #(
  parameter int unsigned WIN_CYC   = culi_pkg::WINDOW_CYC,
  parameter int unsigned FULL_BITS = culi_pkg::FULL_LOAD_BITS
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       win_end,
  input  wire logic [7:0] bits_in,
  output logic [3:0]      segs
);
  import culi_pkg::*;
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [3:0]  segs_q;
  logic [35:0] scaled;
  logic [35:0] lim;

  // Bits taken on the closing edge open the next window, so none are lost
  assign acc_d  = win_end ? {24'h0, bits_in} : acc_q + {24'h0, bits_in};
  // Full load on one direction fills the bar: sum of both spans 100%
  assign scaled = {4'h0, acc_q} * 36'(NSEG);
  assign lim    = scaled / 36'(FULL_BITS);
  assign segs   = segs_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      acc_q  <= 32'h0;
      segs_q <= 4'h0;
    end else begin
      acc_q <= acc_d;
      if (win_end) begin
        segs_q <= (lim > 36'(NSEG)) ? 4'(NSEG) : lim[3:0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/culi_led_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - Colour by category: yellow traffic, green status, red error, white alert, blue system.
// - Off state emits no light.
// - Slow blink toggles with equal on and off time.
// - Fast blink is quicker than slow, still equal halves.
// - On state stays lit without toggling.
// - Dynamic state moves or resizes the lit region over time.
// - Configured and ready shows status area steady white.
// - Until configured, status area fast-blinks blue.
// - Bus-on turns status area from white to green.
// - TX status at USB end, RX status at CAN end.
// - TX bar grows from USB end toward CAN end with TX traffic.
// - RX bar grows from CAN end toward USB end with RX rate.
// - TX status yellow while sending; RX status green while idle.
// - Combined lit length proportional to bus load; full one way equals all.
module culi_led_ctrl #(
  parameter int unsigned SLOW_CYC  = culi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_CYC  = culi_pkg::FAST_HALF_CYC,
  parameter int unsigned WIN_CYC   = culi_pkg::WINDOW_CYC,
  parameter int unsigned STEP_CYC  = culi_pkg::DYN_STEP_CYC,
  parameter int unsigned FULL_BITS = culi_pkg::FULL_LOAD_BITS
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  usb_configured,
  input  wire logic                  bus_on,
  input  wire logic                  err_active,
  input  wire logic                  err_fatal,
  input  wire logic                  alert_active,
  input  wire logic                  sys_active,
  input  wire logic [7:0]            tx_bits,
  input  wire logic [7:0]            rx_bits,
  output culi_pkg::culi_colour_e     tx_stat_colour,
  output culi_pkg::culi_colour_e     rx_stat_colour,
  output logic [culi_pkg::NSEG-1:0]  tx_bar,
  output logic [culi_pkg::NSEG-1:0]  rx_bar,
  output culi_pkg::culi_colour_e     bar_colour
);
  import culi_pkg::*;

  logic [31:0]   slow_cnt_q;
  logic [31:0]   fast_cnt_q;
  logic [31:0]   win_cnt_q;
  logic [31:0]   step_cnt_q;
  logic          slow_ph_q;
  logic          fast_ph_q;
  logic [2:0]    dyn_pos_q;
  logic [3:0]    tx_segs;
  logic [3:0]    rx_segs;
  logic          win_end;
  logic          tx_busy_q;
  logic          rx_busy_q;
  logic          tx_seen_q;
  logic          rx_seen_q;
  culi_colour_e  stat_col;
  culi_pattern_e stat_pat;
  culi_colour_e  tx_col_d;
  culi_colour_e  rx_col_d;
  culi_colour_e  tx_col_q;
  culi_colour_e  rx_col_q;
  logic          stat_lit;
  logic [NSEG-1:0] tx_mask;
  logic [NSEG-1:0] rx_mask;
  logic [NSEG-1:0] dyn_mask;
  logic [NSEG-1:0] tx_bar_q;
  logic [NSEG-1:0] rx_bar_q;
  culi_colour_e  bar_col_q;

  assign win_end = (win_cnt_q == WIN_CYC - 1);

  culi_load_meter #(.WIN_CYC(WIN_CYC), .FULL_BITS(FULL_BITS)) u_tx_meter (
    .mclk    (mclk),
    .reset   (reset),
    .win_end (win_end),
    .bits_in (tx_bits),
    .segs    (tx_segs)
  );

  culi_load_meter #(.WIN_CYC(WIN_CYC), .FULL_BITS(FULL_BITS)) u_rx_meter (
    .mclk    (mclk),
    .reset   (reset),
    .win_end (win_end),
    .bits_in (rx_bits),
    .segs    (rx_segs)
  );

  // Timebases; halves are equal since each phase flips on the same count
  always_ff @(posedge mclk) begin
    if (reset) begin
      slow_cnt_q <= 32'h0;
      fast_cnt_q <= 32'h0;
      win_cnt_q  <= 32'h0;
      step_cnt_q <= 32'h0;
      slow_ph_q  <= 1'b0;
      fast_ph_q  <= 1'b0;
      dyn_pos_q  <= 3'h0;
    end else begin
      if (slow_cnt_q == SLOW_CYC - 1) begin
        slow_cnt_q <= 32'h0;
        slow_ph_q  <= ~slow_ph_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 32'h1;
      end
      if (fast_cnt_q == FAST_CYC - 1) begin
        fast_cnt_q <= 32'h0;
        fast_ph_q  <= ~fast_ph_q;
      end else begin
        fast_cnt_q <= fast_cnt_q + 32'h1;
      end
      win_cnt_q <= win_end ? 32'h0 : win_cnt_q + 32'h1;
      if (step_cnt_q == STEP_CYC - 1) begin
        step_cnt_q <= 32'h0;
        dyn_pos_q  <= dyn_pos_q + 3'h1;
      end else begin
        step_cnt_q <= step_cnt_q + 32'h1;
      end
    end
  end

  // Busy covers the window just ended and the one now running; the
  // seen flags only cover the running window
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
      tx_busy_q <= 1'b0;
      rx_busy_q <= 1'b0;
    end else begin
      if (win_end) begin
        tx_seen_q <= (tx_bits != 8'h0);
        rx_seen_q <= (rx_bits != 8'h0);
        tx_busy_q <= tx_seen_q || (tx_bits != 8'h0);
        rx_busy_q <= rx_seen_q || (rx_bits != 8'h0);
      end else begin
        tx_seen_q <= tx_seen_q || (tx_bits != 8'h0);
        rx_seen_q <= rx_seen_q || (rx_bits != 8'h0);
        tx_busy_q <= tx_busy_q || (tx_bits != 8'h0);
        rx_busy_q <= rx_busy_q || (rx_bits != 8'h0);
      end
    end
  end

  // Shared status: error > alert > system > configured states
  always_comb begin
    stat_col = CULI_WHITE;
    stat_pat = CULI_ST_ON;
    if (err_fatal) begin
      stat_col = CULI_RED;
      stat_pat = CULI_ST_ON;
    end else if (err_active) begin
      stat_col = CULI_RED;
      stat_pat = CULI_ST_FAST;
    end else if (alert_active) begin
      stat_col = CULI_WHITE;
      stat_pat = CULI_ST_SLOW;
    end else if (sys_active) begin
      stat_col = CULI_BLUE;
      stat_pat = CULI_ST_SLOW;
    end else if (!usb_configured) begin
      stat_col = CULI_BLUE;
      stat_pat = CULI_ST_FAST;
    end else if (bus_on) begin
      stat_col = CULI_GREEN;
      stat_pat = CULI_ST_ON;
    end
  end

  always_comb begin
    unique case (stat_pat)
      CULI_ST_OFF:  stat_lit = 1'b0;
      CULI_ST_SLOW: stat_lit = slow_ph_q;
      CULI_ST_FAST: stat_lit = fast_ph_q;
      CULI_ST_ON:   stat_lit = 1'b1;
      CULI_ST_DYN:  stat_lit = 1'b1;
      default:      stat_lit = 1'b0;
    endcase
  end

  // Traffic overrides plain status only; higher classes win
  wire low_prio = usb_configured && bus_on && !err_fatal && !err_active
                  && !alert_active && !sys_active;
  always_comb begin
    tx_col_d = stat_lit ? stat_col : CULI_OFF;
    rx_col_d = stat_lit ? stat_col : CULI_OFF;
    if (low_prio && tx_busy_q) begin
      tx_col_d = CULI_YELLOW;
    end
    if (low_prio && !rx_busy_q) begin
      rx_col_d = CULI_GREEN;
    end else if (low_prio) begin
      rx_col_d = CULI_YELLOW;
    end
  end

  // Bit 0 is the USB end of each bar, bit NSEG-1 the CAN end
  genvar g;
  generate
    for (g = 0; g < NSEG; g++) begin : g_seg
      assign tx_mask[g]  = (4'(g) < tx_segs);
      assign rx_mask[g]  = (4'(NSEG - 1 - g) < rx_segs);
      assign dyn_mask[g] = (3'(g) == dyn_pos_q);
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_col_q  <= CULI_OFF;
      rx_col_q  <= CULI_OFF;
      tx_bar_q  <= '0;
      rx_bar_q  <= '0;
      bar_col_q <= CULI_OFF;
    end else begin
      tx_col_q <= tx_col_d;
      rx_col_q <= rx_col_d;
      if (alert_active && !err_fatal && !err_active) begin
        tx_bar_q  <= {NSEG{slow_ph_q}};
        rx_bar_q  <= {NSEG{slow_ph_q}};
        bar_col_q <= CULI_WHITE;
      end else if (err_active && !err_fatal) begin
        tx_bar_q  <= dyn_mask;
        rx_bar_q  <= ~dyn_mask;
        bar_col_q <= CULI_RED;
      end else if (low_prio) begin
        tx_bar_q  <= tx_mask;
        rx_bar_q  <= rx_mask;
        bar_col_q <= CULI_YELLOW;
      end else begin
        tx_bar_q  <= '0;
        rx_bar_q  <= '0;
        bar_col_q <= CULI_OFF;
      end
    end
  end

  assign tx_stat_colour = tx_col_q;
  assign rx_stat_colour = rx_col_q;
  assign tx_bar         = tx_bar_q;
  assign rx_bar         = rx_bar_q;
  assign bar_colour     = bar_col_q;
endmodule
`default_nettype wire

// ==== bench/culi_led_ctrl_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module culi_led_ctrl_assertions
  import culi_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  usb_configured,
  input wire logic                  bus_on,
  input wire logic                  err_active,
  input wire logic                  err_fatal,
  input wire logic                  alert_active,
  input wire logic                  sys_active,
  input wire culi_pkg::culi_colour_e tx_stat_colour,
  input wire culi_pkg::culi_colour_e rx_stat_colour,
  input wire logic [7:0]            tx_bar,
  input wire logic [7:0]            rx_bar,
  input wire culi_pkg::culi_colour_e bar_colour
);
  wire       quiet = !err_active && !err_fatal && !alert_active && !sys_active;
  wire [7:0] rx_gap = ~rx_bar;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  AST_FATAL: assert property (err_fatal |=>
    tx_stat_colour == CULI_RED && tx_bar == 8'h00 && rx_bar == 8'h00)
    else $error("fatal error not steady red with dark bars");
  AST_ERR: assert property (err_active && !err_fatal |=>
    tx_stat_colour inside {CULI_RED, CULI_OFF})
    else $error("error state not red");
  AST_ALERT: assert property (alert_active && !err_active && !err_fatal |=>
    tx_stat_colour inside {CULI_WHITE, CULI_OFF} &&
    bar_colour inside {CULI_WHITE, CULI_OFF})
    else $error("alert state not white");
  AST_SYS: assert property (sys_active && !alert_active && !err_active &&
    !err_fatal |=> tx_stat_colour inside {CULI_BLUE, CULI_OFF})
    else $error("system state not blue");
  AST_UNCONF: assert property (quiet && !usb_configured |=>
    tx_stat_colour inside {CULI_BLUE, CULI_OFF})
    else $error("unconfigured status not blue");
  AST_READY: assert property (quiet && usb_configured && !bus_on |=>
    tx_stat_colour == CULI_WHITE)
    else $error("ready status not steady white");
  AST_BUSON: assert property (quiet && usb_configured && bus_on |=>
    rx_stat_colour inside {CULI_GREEN, CULI_YELLOW})
    else $error("bus-on status not green or yellow");
  AST_TXFILL: assert property (!err_active && !$past(err_active) |->
    (tx_bar & (tx_bar + 8'h01)) == 8'h00)
    else $error("tx bar not filled from usb end");
  AST_RXFILL: assert property (!err_active && !$past(err_active) |->
    (rx_gap & (rx_gap + 8'h01)) == 8'h00)
    else $error("rx bar not filled from can end");
  AST_DYN: assert property (err_active && !err_fatal |=>
    bar_colour == CULI_RED && $onehot(tx_bar) && rx_bar == ~tx_bar)
    else $error("error bars not a single red dot");
  cover property (err_fatal ##1 tx_stat_colour == CULI_RED);
  cover property (err_active && !err_fatal ##1 bar_colour == CULI_RED);
  cover property (tx_bar == 8'hff);
  cover property (quiet && !usb_configured ##1 tx_stat_colour == CULI_BLUE);
endmodule
bind culi_led_ctrl culi_led_ctrl_assertions u_chk (
  .mclk(mclk), .reset(reset), .usb_configured(usb_configured),
  .bus_on(bus_on), .err_active(err_active), .err_fatal(err_fatal),
  .alert_active(alert_active), .sys_active(sys_active),
  .tx_stat_colour(tx_stat_colour), .rx_stat_colour(rx_stat_colour),
  .tx_bar(tx_bar), .rx_bar(rx_bar), .bar_colour(bar_colour));
`default_nettype wire

// ==== bench/culi_led_bars.sv ====
`timescale 1ns/1ps
`default_nettype none
// Segment bank: a dark colour lights nothing, whatever the bar bits say
module culi_led_bars (
  input  wire logic [7:0]            tx_bar,
  input  wire logic [7:0]            rx_bar,
  input  wire culi_pkg::culi_colour_e bar_colour,
  output logic [3:0]                 tx_lit,
  output logic [3:0]                 rx_lit
);
  import culi_pkg::*;
  wire dark = bar_colour == CULI_OFF;
  assign tx_lit = dark ? 4'h0 : 4'($countones(tx_bar));
  assign rx_lit = dark ? 4'h0 : 4'($countones(rx_bar));
endmodule
`default_nettype wire

// ==== bench/can_usb_led_indicator_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module can_usb_led_indicator_tb;
  import culi_pkg::*;
  typedef struct { logic [5:0] in; culi_colour_e col; int on; } culi_row_s;
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  logic [5:0]   in_v = 6'h00;
  logic [7:0]   tx_bits = 8'h00;
  logic [7:0]   rx_bits = 8'h00;
  culi_colour_e tx_c, rx_c, bar_c;
  logic [7:0]   tx_bar, rx_bar, bar_snap;
  logic [3:0]   tx_lit, rx_lit;
  int           n_mismatch = 0, n_compared = 0, cyc = 0, lit;
  // Lit count over 16 cycles: 16 steady, 8 for either blink rate
  culi_row_s rows [8] = '{'{6'h00, CULI_BLUE, 8}, '{6'h20, CULI_WHITE, 16},
    '{6'h30, CULI_GREEN, 16}, '{6'h38, CULI_RED, 8}, '{6'h3c, CULI_RED, 16},
    '{6'h32, CULI_WHITE, 8}, '{6'h31, CULI_BLUE, 8}, '{6'h33, CULI_WHITE, 8}};
  culi_led_ctrl #(.SLOW_CYC(8), .FAST_CYC(4), .WIN_CYC(64), .STEP_CYC(4),
    .FULL_BITS(128)) u_dut (.mclk(mclk), .reset(reset),
    .usb_configured(in_v[5]), .bus_on(in_v[4]), .err_active(in_v[3]),
    .err_fatal(in_v[2]), .alert_active(in_v[1]), .sys_active(in_v[0]),
    .tx_bits(tx_bits), .rx_bits(rx_bits), .tx_stat_colour(tx_c),
    .rx_stat_colour(rx_c), .tx_bar(tx_bar), .rx_bar(rx_bar),
    .bar_colour(bar_c));
  culi_led_bars u_bars (.tx_bar(tx_bar), .rx_bar(rx_bar), .bar_colour(bar_c),
    .tx_lit(tx_lit), .rx_lit(rx_lit));
  always #20 mclk = ~mclk;
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs about 560 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    cycles(6);
    reset = 1'b0;
    foreach (rows[i]) begin
      in_v = rows[i].in;
      cycles(2);
      lit = 0;
      repeat (16) begin
        @(negedge mclk);
        if (tx_c !== CULI_OFF) begin
          lit++;
          `CHK("tx colour", rows[i].col, tx_c)
        end
      end
      `CHK("lit cycles", rows[i].on, lit)
      $display("row %0d done", i);
    end
    in_v = 6'h30;
    tx_bits = 8'h01;
    rx_bits = 8'h01;
    cycles(200);
    `CHK("tx bar", 8'h0f, tx_bar)
    `CHK("rx bar", 8'hf0, rx_bar)
    `CHK("total lit", 5'd8, tx_lit + rx_lit)
    `CHK("tx status", CULI_YELLOW, tx_c)
    `CHK("bar colour", CULI_YELLOW, bar_c)
    tx_bits = 8'h02;
    rx_bits = 8'h00;
    cycles(200);
    `CHK("tx bar full", 8'hff, tx_bar)
    `CHK("rx bar idle", 8'h00, rx_bar)
    `CHK("rx status", CULI_GREEN, rx_c)
    $display("traffic done");
    in_v = 6'h38;
    cycles(2);
    bar_snap = tx_bar;
    `CHK("dyn colour", CULI_RED, bar_c)
    `CHK("dyn rx", ~bar_snap, rx_bar)
    cycles(4);
    `CHK("dyn move", {bar_snap[6:0], bar_snap[7]}, tx_bar)
    $display("dynamic done");
    in_v = 6'h30;
    reset = 1'b1;
    cycles(2);
    `CHK("reset colour", CULI_OFF, tx_c)
    reset = 1'b0;
    cycles(1);
    `CHK("post reset status", CULI_GREEN, tx_c)
    cycles(1);
    `CHK("post reset busy", CULI_YELLOW, tx_c)
    `CHK("post reset bar", 8'h00, tx_bar)
    $display("reset done");
    finish_test();
  end
endmodule
`default_nettype wire
